//--- src/cpu_program_sequencer.sv
// program sequencer core: phases, pc, return stack, alu, apb registers
// Behaviour
// - four phases form one instruction cycle
// - T1 advances pc and fetches; rest execute
// - next fetch overlaps current execution
// - branches cost one extra instruction cycle
// - pc increments unless flow changes
// - address is bank bits, high section, low byte
// - low pc byte writable, jump within page
// - low byte write inserts one dummy cycle
// - taken skip discards fetched instruction
// - jump, call, interrupt, reset load pc
// - stack holds eight pcs, hidden from software
// - call/interrupt push; returns pop pc
// - reset empties stack pointer to top
// - full stack holds off interrupt acknowledge
// - call on full stack loses oldest entry
// - eight-bit alu writes result to accumulator
// - alu updates carry and zero status
// - execution starts at address zero
`timescale 1ns/1ps
module cpu_program_sequencer #(
  parameter int                BANK_BITS  = 1,        // program_bank_select_field width
  parameter logic [12:0]       INT_VECTOR = 13'h0004  // interrupt entry offset in bank
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  output logic [BANK_BITS+12:0]          prog_addr,
  input  wire logic [15:0]               prog_data,
  output logic                           prog_rd,
  input  wire logic                      irq_pin,
  output logic                           int_ack,
  output seq_pkg::phase_t                instruction_phases
);
  import seq_pkg::*;

  localparam int PC_W = BANK_BITS + PC_CORE_W;

  // phase and fetch/execute pipeline state
  phase_t                  phase_r,   phase_nxt;    // current instruction phase
  logic [PC_W-1:0]         pc_r,      pc_nxt;       // address of next fetch
  logic [15:0]             fet_r,     fet_nxt;      // word fetched, not yet executing
  logic [15:0]             ir_r,      ir_nxt;       // word in execution
  logic                    flush_r,   flush_nxt;    // next ir becomes a dummy
  // accumulator and status
  logic [7:0]              acc_r,     acc_nxt;
  logic                    carry_r,   carry_nxt;
  logic                    zero_r,    zero_nxt;
  // return stack, circular so an overflow overwrites the oldest level
  logic [PC_W-1:0]         stack_mem [STACK_DEPTH];
  logic [STACK_IDX_W-1:0]  top_r,     top_nxt;      // index of newest level
  logic [STACK_CNT_W-1:0]  cnt_r,     cnt_nxt;      // levels in use, saturates
  logic                    push;                    // write pc into next level
  logic [PC_W-1:0]         push_val;
  // software visible control
  logic [BANK_BITS-1:0]    bank_r,    bank_nxt;     // program_bank_select_field
  logic                    run_r,     run_nxt;
  logic                    gie_r,     gie_nxt;
  logic                    pcl_req_r, pcl_req_nxt;  // software wrote pc_low_byte
  logic [7:0]              pcl_val_r, pcl_val_nxt;
  logic                    pend_r,    pend_nxt;     // recorded interrupt request
  // interrupt pin synchroniser
  logic [2:0]              irq_sync_r;
  logic                    irq_lvl_r;               // filtered level
  // bus and decode helpers
  logic                    wr_en;
  logic                    rd_en;
  logic                    addr_ok;
  logic [31:0]             rdata_nxt;
  logic                    tick_t1;
  logic                    tick_t4;
  opcode_t                 op;
  logic                    is_flow;                 // ir may change flow
  logic                    stack_full;
  logic                    ack;
  logic                    irq_rise;
  alu_req_t                alu_req;
  alu_res_t                alu_rsp;

  seq_alu u_alu (
    .req (alu_req),
    .rsp (alu_rsp)
  );

  // apb decode; every access completes without wait states
  assign pready  = 1'b1;
  assign addr_ok = (paddr == OFS_PC_LOW) || (paddr == OFS_CONTROL) ||
                   (paddr == OFS_STATE)  || (paddr == OFS_PC_FULL);
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_en   = psel & penable & pwrite & addr_ok;
  assign rd_en   = psel & ~penable & ~pwrite;

  // phase ticks; the run bit freezes the phase divider
  assign tick_t1 = run_r && (phase_r == PH_T1);
  assign tick_t4 = run_r && (phase_r == PH_T4);
  assign prog_rd = tick_t1;
  assign prog_addr          = pc_r;
  assign instruction_phases = phase_r;

  // instruction decode for the word in execution
  assign op         = opcode_t'(ir_r[OP_MSB:OP_LSB]);
  assign is_flow    = (op == OP_JUMP) || (op == OP_CALL) || (op == OP_SKZ) ||
                      (op == OP_SKNZ) || (op == OP_PCLW) ||
                      ((op == OP_MISC) && (ir_r[1:0] != 2'b00));
  assign stack_full = (cnt_r == STACK_CNT_W'(STACK_DEPTH));
  // no acknowledge on a full stack; the flag waits for a return
  assign ack        = tick_t4 && pend_r && gie_r && !stack_full && !is_flow;
  assign int_ack    = ack;
  assign irq_rise   = (irq_sync_r[2] == irq_sync_r[1]) && irq_sync_r[1] && !irq_lvl_r;

  // alu operand selection
  always_comb begin
    alu_req.op  = alu_op_t'(ir_r[ALUOP_MSB:ALUOP_LSB]);
    alu_req.a   = acc_r;
    alu_req.b   = ir_r[7:0];
    alu_req.cin = carry_r;
  end

  // next-state of the sequencer
  always_comb begin
    phase_nxt   = phase_r;
    pc_nxt      = pc_r;
    fet_nxt     = fet_r;
    ir_nxt      = ir_r;
    flush_nxt   = flush_r;
    acc_nxt     = acc_r;
    carry_nxt   = carry_r;
    zero_nxt    = zero_r;
    top_nxt     = top_r;
    cnt_nxt     = cnt_r;
    push        = 1'b0;
    push_val    = pc_r - PC_W'(1);  // address of the word sitting in fet_r
    gie_nxt     = gie_r;
    pend_nxt    = pend_r;
    pcl_req_nxt = pcl_req_r;
    if (run_r) begin
      phase_nxt = phase_t'(phase_r + 2'b01);
    end
    // T1: advance pc, fetch the next word while ir executes
    if (tick_t1) begin
      ir_nxt    = flush_r ? NOP_WORD : fet_r;
      fet_nxt   = prog_data;
      pc_nxt    = pc_r + PC_W'(1);
      flush_nxt = 1'b0;
    end
    // T4: interrupt entry; the sequential word in ir still completes,
    // otherwise an alu result would be lost across the service routine
    if (ack) begin
      push      = 1'b1;
      pc_nxt    = {bank_r, INT_VECTOR};
      flush_nxt = 1'b1;
      gie_nxt   = 1'b0;
      pend_nxt  = 1'b0;
    end
    if (tick_t4) begin
      unique case (op)
        OP_JUMP: begin
          pc_nxt    = {bank_r, ir_r[PC_CORE_W-1:0]};
          flush_nxt = 1'b1;
        end
        OP_CALL: begin
          push      = 1'b1;
          pc_nxt    = {bank_r, ir_r[PC_CORE_W-1:0]};
          flush_nxt = 1'b1;
        end
        OP_ALU: begin
          acc_nxt   = alu_rsp.res;
          carry_nxt = alu_rsp.cout;
          zero_nxt  = alu_rsp.zero;
        end
        OP_SKZ: begin
          flush_nxt = zero_r;
        end
        OP_SKNZ: begin
          flush_nxt = !zero_r;
        end
        OP_PCLW: begin
          pc_nxt    = {pc_r[PC_W-1:PC_LOW_W], acc_r};
          flush_nxt = 1'b1;
        end
        OP_LDI: begin
          acc_nxt   = ir_r[7:0];
          zero_nxt  = (ir_r[7:0] == 8'h00);
        end
        OP_MISC: begin
          if (ir_r[1:0] == 2'b01 || ir_r[1:0] == 2'b10) begin
            pc_nxt    = stack_mem[top_r];
            top_nxt   = top_r - STACK_IDX_W'(1);
            flush_nxt = 1'b1;
            if (cnt_r != '0) begin
              cnt_nxt = cnt_r - STACK_CNT_W'(1);
            end
            if (ir_r[1:0] == 2'b10) begin
              gie_nxt = 1'b1;
            end
          end
        end
      endcase
      // software short jump within the page, when the word is sequential
      if (pcl_req_r && !is_flow && !ack) begin
        pc_nxt      = {pc_r[PC_W-1:PC_LOW_W], pcl_val_r};
        flush_nxt   = 1'b1;
        pcl_req_nxt = 1'b0;
      end
    end
    if (push) begin
      top_nxt = top_r + STACK_IDX_W'(1);
      if (!stack_full) begin
        cnt_nxt = cnt_r + STACK_CNT_W'(1);
      end
    end
    // a fresh request beats its own clear
    if (irq_rise) begin
      pend_nxt = 1'b1;
    end
    // bus writes land last, so software wins over entry and return
    if (wr_en && paddr == OFS_CONTROL) begin
      gie_nxt = pwdata[CTL_GIE_BIT];
    end
    // a fresh short jump request beats its own clear
    if (wr_en && paddr == OFS_PC_LOW) begin
      pcl_req_nxt = 1'b1;
    end
  end

  // register writes from the bus
  always_comb begin
    bank_nxt    = bank_r;
    run_nxt     = run_r;
    pcl_val_nxt = pcl_val_r;
    if (wr_en && paddr == OFS_CONTROL) begin
      bank_nxt = pwdata[CTL_BANK_LSB +: BANK_BITS];
      run_nxt  = pwdata[CTL_RUN_BIT];
    end
    if (wr_en && paddr == OFS_PC_LOW) begin
      pcl_val_nxt = pwdata[7:0];
    end
  end

  // read mux; stack contents and level never appear here
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (rd_en) begin
      unique case (paddr)
        OFS_PC_LOW:  rdata_nxt[7:0] = pc_r[PC_LOW_W-1:0];
        OFS_CONTROL: begin
          rdata_nxt[CTL_BANK_LSB +: BANK_BITS] = bank_r;
          rdata_nxt[CTL_RUN_BIT] = run_r;
          rdata_nxt[CTL_GIE_BIT] = gie_r;
        end
        OFS_STATE: begin
          rdata_nxt[7:0]            = acc_r;
          rdata_nxt[ST_CARRY_BIT]   = carry_r;
          rdata_nxt[ST_ZERO_BIT]    = zero_r;
          rdata_nxt[ST_PEND_BIT]    = pend_r;
          rdata_nxt[ST_PHASE_LSB +: 2] = phase_r;
        end
        OFS_PC_FULL: rdata_nxt[PC_W-1:0] = pc_r;
        default:     rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // state registers; reset lands on the entry point with empty stack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r   <= PH_T1;
      pc_r      <= {{BANK_BITS{1'b0}}, RESET_ENTRY};
      fet_r     <= NOP_WORD;
      ir_r      <= NOP_WORD;
      flush_r   <= 1'b0;
      acc_r     <= 8'h00;
      carry_r   <= 1'b0;
      zero_r    <= 1'b0;
      top_r     <= '0;
      cnt_r     <= '0;
      bank_r    <= '0;
      run_r     <= RUN_RST;
      gie_r     <= GIE_RST;
      pcl_req_r <= 1'b0;
      pcl_val_r <= 8'h00;
      pend_r    <= 1'b0;
      prdata    <= 32'h0000_0000;
    end else begin
      phase_r   <= phase_nxt;
      pc_r      <= pc_nxt;
      fet_r     <= fet_nxt;
      ir_r      <= ir_nxt;
      flush_r   <= flush_nxt;
      acc_r     <= acc_nxt;
      carry_r   <= carry_nxt;
      zero_r    <= zero_nxt;
      top_r     <= top_nxt;
      cnt_r     <= cnt_nxt;
      bank_r    <= bank_nxt;
      run_r     <= run_nxt;
      gie_r     <= gie_nxt;
      pcl_req_r <= pcl_req_nxt;
      pcl_val_r <= pcl_val_nxt;
      pend_r    <= pend_nxt;
      prdata    <= rdata_nxt;
    end
  end

  // stack storage has no reset; a return right after reset reads level 0 before any push
  always_ff @(posedge pclk) begin
    if (push) begin
      stack_mem[top_r + STACK_IDX_W'(1)] <= push_val;
    end
  end

  // irq pin: three stages, level moves once the last two agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sync_r <= 3'b000;
      irq_lvl_r  <= 1'b0;
    end else begin
      irq_sync_r <= {irq_sync_r[1:0], irq_pin};
      if (irq_sync_r[2] == irq_sync_r[1]) begin
        irq_lvl_r <= irq_sync_r[2];
      end
    end
  end
endmodule : cpu_program_sequencer

//--- src/seq_alu.sv
// eight-bit alu with carry and zero outputs
`timescale 1ns/1ps
module seq_alu (
  input  seq_pkg::alu_req_t req,
  output seq_pkg::alu_res_t rsp
);
  import seq_pkg::*;

  logic [8:0] wide;  // result with carry or borrow in bit 8

  // purely combinational; the sequencer registers the outcome at T4
  always_comb begin
    wide = 9'h000;
    unique case (req.op)
      ALU_ADD: wide = {1'b0, req.a} + {1'b0, req.b} + {8'h00, req.cin};
      ALU_SUB: wide = {1'b0, req.a} - {1'b0, req.b};  // bit 8 set means borrow
      ALU_AND: wide = {req.cin, req.a & req.b};
      ALU_OR:  wide = {req.cin, req.a | req.b};
      ALU_XOR: wide = {req.cin, req.a ^ req.b};
      ALU_RRC: wide = {req.a[0], req.cin, req.a[7:1]};
      ALU_INC: wide = {req.cin, req.a + 8'h01};  // carry untouched
      ALU_DEC: wide = {req.cin, req.a - 8'h01};
    endcase
    rsp.res  = wide[7:0];
    rsp.cout = wide[8];
    rsp.zero = (wide[7:0] == 8'h00);
  end
endmodule : seq_alu

//--- src/seq_pkg.sv
// shared constants, encodings and carriers for the program sequencer
package seq_pkg;
  // address layout of the program counter
  localparam int PC_LOW_W     = 8;        // software-visible low byte
  localparam int PC_HIGH_W    = 5;        // counter section above the low byte
  localparam int PC_CORE_W    = PC_LOW_W + PC_HIGH_W;
  localparam int STACK_DEPTH  = 8;        // return stack levels
  localparam int STACK_IDX_W  = 3;
  localparam int STACK_CNT_W  = 4;

  // register offsets on the apb bus (byte addresses)
  localparam logic [7:0] OFS_PC_LOW  = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_STATE   = 8'h08;
  localparam logic [7:0] OFS_PC_FULL = 8'h0c;

  // control register fields
  localparam int CTL_BANK_LSB = 0;        // program_bank_select_field
  localparam int CTL_RUN_BIT  = 8;        // phases advance while set
  localparam int CTL_GIE_BIT  = 9;        // global interrupt enable
  localparam logic RUN_RST    = 1'b1;
  localparam logic GIE_RST    = 1'b0;

  // state register fields
  localparam int ST_CARRY_BIT = 8;
  localparam int ST_ZERO_BIT  = 9;
  localparam int ST_PEND_BIT  = 10;
  localparam int ST_PHASE_LSB = 12;

  // instruction word layout
  localparam int OP_MSB      = 15;
  localparam int OP_LSB      = 13;
  localparam int ALUOP_MSB   = 12;
  localparam int ALUOP_LSB   = 10;
  localparam logic [15:0] NOP_WORD = 16'h0000;

  // reset entry point
  localparam logic [PC_CORE_W-1:0] RESET_ENTRY = 13'h0000;

  typedef enum logic [1:0] {
    PH_T1 = 2'b00,
    PH_T2 = 2'b01,
    PH_T3 = 2'b10,
    PH_T4 = 2'b11
  } phase_t;

  typedef enum logic [2:0] {
    OP_MISC  = 3'b000,  // [1:0]: 0 nop, 1 subroutine_return_op, 2 interrupt_return_op
    OP_JUMP  = 3'b001,  // jump_op, 13-bit target
    OP_CALL  = 3'b010,
    OP_ALU   = 3'b011,  // acc <= acc op imm
    OP_SKZ   = 3'b100,  // skip next when zero flag set
    OP_SKNZ  = 3'b101,  // skip next when zero flag clear
    OP_PCLW  = 3'b110,  // pc_low_byte <= acc
    OP_LDI   = 3'b111   // acc <= imm
  } opcode_t;

  typedef enum logic [2:0] {
    ALU_ADD = 3'b000,
    ALU_SUB = 3'b001,
    ALU_AND = 3'b010,
    ALU_OR  = 3'b011,
    ALU_XOR = 3'b100,
    ALU_RRC = 3'b101,
    ALU_INC = 3'b110,
    ALU_DEC = 3'b111
  } alu_op_t;

  typedef struct packed {
    alu_op_t    op;
    logic [7:0] a;
    logic [7:0] b;
    logic       cin;
  } alu_req_t;

  typedef struct packed {
    logic [7:0] res;
    logic       cout;
    logic       zero;
  } alu_res_t;
endpackage : seq_pkg

//--- tb/cpu_program_sequencer_chk.sv
// port-level assertions for the program sequencer
`timescale 1ns/1ps
module cpu_program_sequencer_chk #(
  parameter int          BANK_BITS  = 1,
  parameter logic [12:0] INT_VECTOR = 13'h0004
) (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic [BANK_BITS+12:0] prog_addr,
  input wire logic [15:0]           prog_data,
  input wire logic                  prog_rd,
  input wire logic                  irq_pin,
  input wire logic                  int_ack,
  input wire seq_pkg::phase_t       instruction_phases
);
  import seq_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;  // access hits a decoded register
  assign mapped = paddr inside {OFS_PC_LOW, OFS_CONTROL, OFS_STATE, OFS_PC_FULL};
  // fetch phase handing over to decode
  sequence s_fetch_done;
    $past(instruction_phases) == PH_T1 && instruction_phases == PH_T2;
  endsequence
  // acknowledge in the last phase
  sequence s_ack;
    int_ack && instruction_phases == PH_T4;
  endsequence
  chk_phase_step: assert property (
    $changed(instruction_phases) |->
    instruction_phases == phase_t'($past(instruction_phases) + 2'd1))
    else $error("phase skipped a step");
  chk_fetch_phase: assert property (prog_rd |-> instruction_phases == PH_T1)
    else $error("fetch outside first phase");
  chk_pc_increment: assert property (
    s_fetch_done |-> prog_addr[12:0] == $past(prog_addr[12:0]) + 13'h1)
    else $error("counter not advanced after fetch");
  chk_pc_moves: assert property (
    $changed(prog_addr[12:0]) |-> $past(instruction_phases) inside {PH_T1, PH_T4})
    else $error("counter moved mid cycle");
  chk_ack_phase: assert property (int_ack |-> instruction_phases == PH_T4)
    else $error("acknowledge outside last phase");
  chk_ack_vector: assert property (s_ack |=> prog_addr[12:0] == INT_VECTOR)
    else $error("acknowledge without vector load");
  chk_ack_spacing: assert property (int_ack |=> (!int_ack) [*3])
    else $error("acknowledge repeated");
  chk_reset_entry: assert property (
    $rose(presetn) |-> prog_addr == '0 && instruction_phases == PH_T1)
    else $error("reset entry not at zero");
  chk_zero_wait: assert property (psel && penable |-> pready)
    else $error("wait state inserted");
  chk_unmapped_err: assert property (psel && penable |-> pslverr == !mapped)
    else $error("error response wrong");
  chk_unmapped_data: assert property (
    psel && penable && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read returned data");
endmodule : cpu_program_sequencer_chk

bind cpu_program_sequencer cpu_program_sequencer_chk #(
  .BANK_BITS(BANK_BITS), .INT_VECTOR(INT_VECTOR)
) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .prog_addr(prog_addr), .prog_data(prog_data), .prog_rd(prog_rd), .irq_pin(irq_pin),
  .int_ack(int_ack), .instruction_phases(instruction_phases)
);

//--- tb/cpu_program_sequencer_tb.sv
// self-checking bench: programs run from the memory model, checked over apb
`timescale 1ns/1ps
module cpu_program_sequencer_tb;
  import seq_pkg::*;
  localparam logic [12:0] INT_VEC = 13'h0004;  // interrupt entry
  logic        pclk = 1'b0;     // 125 MHz
  logic        presetn = 1'b0;  // async reset
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [13:0] prog_addr;       // one bank bit above 13
  logic [15:0] prog_data;
  logic        prog_rd;
  logic        irq_pin = 1'b0;
  logic        int_ack;
  phase_t      phase;
  int          bad_count = 0;   // mismatches
  int          n_tests = 0;     // comparisons
  int          acks = 0;        // acknowledges seen
  logic [31:0] rd_q;            // last read data
  logic        err_q;           // last error response

  cpu_program_sequencer #(.BANK_BITS(1), .INT_VECTOR(INT_VEC)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .prog_addr(prog_addr), .prog_data(prog_data), .prog_rd(prog_rd), .irq_pin(irq_pin),
    .int_ack(int_ack), .instruction_phases(phase));
  seq_prog_mem #(.AW(14)) i_mem (.clk(pclk), .addr(prog_addr), .rd(prog_rd), .data(prog_data));

  always #4 pclk = ~pclk;
  // count acknowledge pulses as the design drives them
  always @(posedge pclk) begin
    if (int_ack === 1'b1) acks <= acks + 1;
  end

  function automatic logic [15:0] wi(opcode_t o, logic [12:0] f);
    return {o, f};
  endfunction : wi
  function automatic logic [15:0] ld(logic [7:0] v);
    return {OP_LDI, 5'h00, v};
  endfunction : ld
  function automatic logic [15:0] al(alu_op_t op, logic [7:0] v);
    return {OP_ALU, op, 2'b00, v};
  endfunction : al
  // reference result, carry on top
  function automatic logic [8:0] alu_ref(alu_op_t op, logic [7:0] a, logic [7:0] b);
    case (op)
      ALU_ADD: return {1'b0, a} + {1'b0, b};
      ALU_SUB: return {a < b, a - b};
      ALU_AND: return {1'b0, a & b};
      ALU_OR:  return {1'b0, a | b};
      ALU_XOR: return {1'b0, a ^ b};
      ALU_RRC: return {a[0], 1'b0, a[7:1]};
      ALU_INC: return {1'b0, a + 8'h01};
      default: return {1'b0, a - 8'h01};
    endcase
  endfunction : alu_ref

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one apb transfer; the request holds until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      check("apb ready", 32'(pready), 32'h1);
      test_done();
    end
  endtask : apb
  // memory is reloaded only while the core is held in reset
  task automatic reset_on();
    @(posedge pclk);
    presetn <= 1'b0;
    i_mem.clear();
  endtask : reset_on
  task automatic reset_off();
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
  endtask : reset_off
  // bounded wait for a fetch address, then let the executing word finish
  task automatic wait_pc(input logic [12:0] t);
    int n;
    n = 0;
    while (prog_addr[12:0] !== t && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 2000) begin
      check("fetch address", 32'(prog_addr[12:0]), 32'(t));
      test_done();
    end
    repeat (12) @(posedge pclk);
  endtask : wait_pc

  // load, operate, loop; flags read back over the bus
  task automatic alu_case(input alu_op_t op);
    logic [8:0] e;
    e = alu_ref(op, 8'h81, 8'h7f);
    reset_on();
    i_mem.mem[0] = ld(8'h81);
    i_mem.mem[1] = al(op, 8'h7f);
    i_mem.mem[2] = wi(OP_JUMP, 13'h0002);
    reset_off();
    wait_pc(13'h0002);
    apb(1'b0, OFS_STATE, 32'h0);
    check("alu result", 32'(rd_q[7:0]), 32'(e[7:0]));
    check("zero flag", 32'(rd_q[ST_ZERO_BIT]), 32'(e[7:0] == 8'h00));
    // logic, inc and dec keep the clear carry left by reset
    check("carry flag", 32'(rd_q[ST_CARRY_BIT]), 32'(e[8]));
  endtask : alu_case

  // the words that the first jump, both taken skips and pclw discard would spoil the accumulator
  task automatic flow_case();
    logic [31:0] pc_q;  // counter seen once the phases stop
    reset_on();
    i_mem.mem[13'h000] = ld(8'h05);
    i_mem.mem[13'h001] = wi(OP_JUMP, 13'h0010);
    i_mem.mem[13'h002] = ld(8'hee);
    i_mem.mem[13'h010] = al(ALU_ADD, 8'hfb);
    i_mem.mem[13'h011] = wi(OP_SKZ, 13'h0000);
    i_mem.mem[13'h012] = ld(8'h77);
    i_mem.mem[13'h013] = wi(OP_CALL, 13'h0020);
    i_mem.mem[13'h014] = wi(OP_SKZ, 13'h0000);
    i_mem.mem[13'h015] = ld(8'h40);
    i_mem.mem[13'h016] = wi(OP_PCLW, 13'h0000);
    i_mem.mem[13'h017] = ld(8'h99);
    i_mem.mem[13'h020] = al(ALU_SUB, 8'h01);
    i_mem.mem[13'h021] = wi(OP_SKNZ, 13'h0000);
    i_mem.mem[13'h022] = ld(8'haa);
    i_mem.mem[13'h023] = wi(OP_MISC, 13'h0001);
    i_mem.mem[13'h040] = al(ALU_XOR, 8'h0f);
    i_mem.mem[13'h041] = wi(OP_JUMP, 13'h0041);
    reset_off();
    apb(1'b0, OFS_CONTROL, 32'h0);
    check("control reset", rd_q, 32'h0000_0100);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped error", 32'(err_q), 32'h1);
    wait_pc(13'h0041);
    apb(1'b0, OFS_STATE, 32'h0);
    check("flow accumulator", 32'(rd_q[7:0]), 32'h4f);
    apb(1'b1, OFS_CONTROL, 32'h0000_0101);
    repeat (12) @(posedge pclk);
    apb(1'b0, OFS_PC_FULL, 32'h0);
    check("bank bit", 32'(rd_q[13]), 32'h1);
    // clearing run stops the phases, so the counter must stand still
    apb(1'b1, OFS_CONTROL, 32'h0000_0001);
    apb(1'b0, OFS_PC_FULL, 32'h0);
    pc_q = rd_q;
    repeat (9) @(posedge pclk);
    apb(1'b0, OFS_PC_FULL, 32'h0);
    check("frozen pc", rd_q, pc_q);
  endtask : flow_case

  // nine nested calls, interrupt held off while full
  task automatic stack_case();
    int a0;
    reset_on();
    i_mem.mem[13'h000] = ld(8'h01);
    i_mem.mem[13'h001] = wi(OP_CALL, 13'h0010);
    i_mem.mem[13'h002] = ld(8'h55);
    i_mem.mem[13'h003] = wi(OP_JUMP, 13'h0003);
    i_mem.mem[INT_VEC] = wi(OP_MISC, 13'h0002);
    i_mem.mem[13'h010] = wi(OP_CALL, 13'h0013);
    i_mem.mem[13'h011] = wi(OP_JUMP, 13'h0030);
    for (int i = 1; i < 8; i++) begin
      i_mem.mem[16 + 3 * i] = wi(OP_CALL, 13'(19 + 3 * i));
      i_mem.mem[17 + 3 * i] = al(ALU_INC, 8'h00);
      i_mem.mem[18 + 3 * i] = wi(OP_MISC, 13'h0001);
    end
    i_mem.mem[13'h028] = wi(OP_JUMP, 13'h0028);
    i_mem.mem[13'h029] = wi(OP_MISC, 13'h0001);
    i_mem.mem[13'h030] = wi(OP_JUMP, 13'h0030);
    reset_off();
    a0 = acks;
    apb(1'b1, OFS_CONTROL, 32'h0000_0300);
    wait_pc(13'h0028);
    irq_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    irq_pin <= 1'b0;
    repeat (30) @(posedge pclk);
    apb(1'b0, OFS_STATE, 32'h0);
    check("held request", 32'(rd_q[ST_PEND_BIT]), 32'h1);
    check("held acknowledge", 32'(acks - a0), 32'h0);
    apb(1'b1, OFS_PC_LOW, 32'h0000_0029);
    wait_pc(13'h0030);
    check("late acknowledge", 32'(acks - a0), 32'h1);
    apb(1'b0, OFS_STATE, 32'h0);
    check("return count", 32'(rd_q[7:0]), 32'h08);
  endtask : stack_case

  initial begin
    for (int k = 0; k < 8; k++) begin
      alu_case(alu_op_t'(k));
    end
    flow_case();
    stack_case();
    test_done();
  end
endmodule : cpu_program_sequencer_tb

//--- tb/seq_prog_mem.sv
// program memory model feeding the sequencer fetch port
`timescale 1ns/1ps
module seq_prog_mem #(
  parameter int AW = 14  // fetch address width
) (
  input  wire logic          clk,
  input  wire logic [AW-1:0] addr,
  input  wire logic          rd,
  output logic [15:0]        data
);
  logic [15:0] mem [0:(1<<AW)-1];  // words loaded by the bench
  logic [15:0] last_q = 16'h0000;  // word last handed out
  // outside a fetch the bus shows the inverse of the last word,
  // so a late sample cannot pass for a valid instruction
  always_comb begin
    data = rd ? mem[addr] : ~last_q;
  end
  // remember what was read
  always @(posedge clk) begin
    if (rd) last_q <= mem[addr];
  end
  // fill with no-operation words
  task automatic clear();
    for (int i = 0; i < (1<<AW); i++) mem[i] = 16'h0000;
  endtask : clear
endmodule : seq_prog_mem
